// File: cab_pkg.sv
package cab_pkg;
    // information word layout
    localparam int WORD_W     = 16;
    localparam int CAUSE_W    = 3;
    localparam int BODY_W     = WORD_W - CAUSE_W;
    localparam int INTR_DW    = 12;
    localparam int WSEL_W     = 3;
    localparam int XADDR_W    = 24;
    localparam int XHI_W      = 8;
    localparam int XLO_W      = 16;
    localparam int DMA_BIT_LO = 9;
    localparam int DMA_BIT_HI = 10;

    localparam logic [CAUSE_W-1:0] CAUSE_INTR = 3'h4;
    localparam logic [CAUSE_W-1:0] CAUSE_HALT = 3'h5;
    localparam logic [CAUSE_W-1:0] CAUSE_DMA  = 3'h6;
    localparam logic [CAUSE_W-1:0] CAUSE_EXEC = 3'h7;
    localparam logic [3:0]         INTR_TOP   = 4'h8;

    // variable area word indices
    localparam logic [WSEL_W-1:0] WIDX_STATUS = 3'h0;
    localparam logic [WSEL_W-1:0] WIDX_XHI    = 3'h4;
    localparam logic [WSEL_W-1:0] WIDX_XLO    = 3'h5;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK   = 8'h08;
    localparam logic [7:0] OFS_WORD0  = 8'h0C;
    localparam logic [7:0] OFS_STATE  = 8'h10;

    // sticky event bit positions
    localparam int EV_N    = 4;
    localparam int EV_INTR = 0;
    localparam int EV_HALT = 1;
    localparam int EV_DMA  = 2;
    localparam int EV_EXEC = 3;

    localparam logic [31:0] RST_CTRL = 32'h0000_0001;
    localparam logic [3:0]  RST_MASK = 4'h0;

    typedef enum logic [2:0] {K_NONE, K_INTR, K_HALT, K_DMA, K_EXEC}
        cab_kind_type;
endpackage

// File: cab_irq_unit.sv
// sticky event status, mask and level interrupt
module cab_irq_unit
    import cab_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic [EV_N-1:0] set_i,
    input  wire logic            rd_clr_i,
    input  wire logic            mask_we_i,
    input  wire logic [EV_N-1:0] mask_d_i,
    output logic      [EV_N-1:0] status_o,
    output logic      [EV_N-1:0] mask_o,
    output logic                 irq_o
);
    logic [EV_N-1:0] status_next;
    logic [EV_N-1:0] mask_next;

    // a set in the same cycle as the clearing read survives it
    assign status_next = (rd_clr_i ? '0 : status_o) | set_i;
    assign mask_next   = mask_we_i ? mask_d_i : mask_o;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            status_o <= '0;
            mask_o   <= RST_MASK;
            irq_o    <= 1'b0;
        end
        else
        begin
            status_o <= status_next;
            mask_o   <= mask_next;
            irq_o    <= |(status_next & mask_next);
        end
    end
endmodule // cab_irq_unit

// File: cab_word_writer.sv
// writes one to three words into the variable area, one at a time
module cab_word_writer
    import cab_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              start_i,
    input  wire logic [1:0]        count_i,
    input  wire logic [WSEL_W-1:0] addr0_i,
    input  wire logic [WORD_W-1:0] data0_i,
    input  wire logic [WSEL_W-1:0] addr1_i,
    input  wire logic [WORD_W-1:0] data1_i,
    input  wire logic [WSEL_W-1:0] addr2_i,
    input  wire logic [WORD_W-1:0] data2_i,
    input  wire logic              mem_ack_i,
    output logic                   mem_we_o,
    output logic      [WSEL_W-1:0] mem_addr_o,
    output logic      [WORD_W-1:0] mem_data_o,
    output logic                   busy_o,
    output logic                   done_o
);
    typedef enum logic {W_IDLE, W_WRITE} cab_wstate_type;
    cab_wstate_type  state_reg;
    logic [1:0]      idx_reg;
    logic [1:0]      cnt_reg;
    logic [WSEL_W-1:0] a1_reg, a2_reg;
    logic [WORD_W-1:0] d1_reg, d2_reg;
    wire             last_w = (idx_reg == cnt_reg - 2'h1);

    // address and data move on only after the memory took the word
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg  <= W_IDLE;
            idx_reg    <= '0;
            cnt_reg    <= '0;
            a1_reg     <= '0;
            a2_reg     <= '0;
            d1_reg     <= '0;
            d2_reg     <= '0;
            mem_we_o   <= 1'b0;
            mem_addr_o <= '0;
            mem_data_o <= '0;
            busy_o     <= 1'b0;
            done_o     <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            unique case (state_reg)
                W_IDLE:
                    if (start_i)
                    begin
                        state_reg  <= W_WRITE;
                        idx_reg    <= '0;
                        cnt_reg    <= count_i;
                        a1_reg     <= addr1_i;
                        a2_reg     <= addr2_i;
                        d1_reg     <= data1_i;
                        d2_reg     <= data2_i;
                        mem_we_o   <= 1'b1;
                        mem_addr_o <= addr0_i;
                        mem_data_o <= data0_i;
                        busy_o     <= 1'b1;
                    end
                W_WRITE:
                    if (mem_ack_i && last_w)
                    begin
                        state_reg <= W_IDLE;
                        mem_we_o  <= 1'b0;
                        busy_o    <= 1'b0;
                        done_o    <= 1'b1;
                    end
                    else if (mem_ack_i)
                    begin
                        idx_reg    <= idx_reg + 2'h1;
                        mem_addr_o <= (idx_reg == 2'h0) ? a1_reg : a2_reg;
                        mem_data_o <= (idx_reg == 2'h0) ? d1_reg : d2_reg;
                    end
            endcase
        end
    end
endmodule // cab_word_writer

// File: cab_channel_abort_status_writer.sv
// How it works
// RULE_01: cause code sits in top three bits
// RULE_02: running program interrupts only via interrupt instruction
// RULE_03: abort and halt status go to word 0
// RULE_04: interrupt instruction writes 1000 plus 12 data bits
// RULE_05: halt while waiting stops at once, silently
// RULE_06: halt during service waits, then interrupts
// RULE_07: deferred halt word is 101 and zeros
// RULE_08: DMA abort word is 110 plus register bits
// RULE_09: memory error saves failing address in words 4,5
// RULE_10: DMA status mismatch aborts without address words
// RULE_11: execution error word is 111 plus flags
// RULE_12: words written before interrupt status is set
module cab_channel_abort_status_writer
    import cab_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // classic wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // channel program events
    input  wire logic               prog_running_i,
    input  wire logic               prog_waiting_i,
    input  wire logic               wait_point_i,
    input  wire logic               intr_instr_i,
    input  wire logic [WSEL_W-1:0]  intr_word_sel_i,
    input  wire logic [INTR_DW-1:0] intr_data_i,
    input  wire logic               halt_io_program_command_i,
    input  wire logic               dma_abort_i,
    input  wire logic               dma_mem_err_i,
    input  wire logic [WORD_W-1:0]  dma_reg_i,
    input  wire logic [XADDR_W-1:0] dma_addr_i,
    input  wire logic               dma_check_i,
    input  wire logic [1:0]         dma_expect_i,
    input  wire logic               exec_err_i,
    input  wire logic [BODY_W-1:0]  exec_flags_i,
    // channel_program_variable_area write port
    input  wire logic               channel_program_variable_area_ack_i,
    output logic                    channel_program_variable_area_we_o,
    output logic      [WSEL_W-1:0]  channel_program_variable_area_addr_o,
    output logic      [WORD_W-1:0]  channel_program_variable_area_data_o,
    output logic                    halt_o,
    output logic                    irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [31:0]       ctrl_reg;
    logic [WORD_W-1:0] word0_reg;
    logic              halt_pend_reg;
    logic              p_intr_reg, p_halt_reg, p_dma_reg, p_exec_reg;
    logic [WORD_W-1:0] intr_word_reg, dma_word_reg, exec_word_reg;
    logic [WSEL_W-1:0] intr_sel_reg;
    logic              dma_addr_ok_reg;
    logic [XADDR_W-1:0] dma_xaddr_reg;
    cab_kind_type      act_kind_reg;
    logic              start_reg;
    logic [1:0]        cnt_reg;
    logic [WSEL_W-1:0] a0_reg, a1_reg, a2_reg;
    logic [WORD_W-1:0] d0_reg, d1_reg, d2_reg;
    logic              wr_busy, wr_done;
    logic [EV_N-1:0]   ev_status, ev_mask, ev_set;

    // bus decode
    wire bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr    = bus_req && wb_we_i;
    wire bus_rd    = bus_req && !wb_we_i;
    wire sel_ctrl  = wb_adr_i == OFS_CTRL;
    wire sel_stat  = wb_adr_i == OFS_STATUS;
    wire sel_mask  = wb_adr_i == OFS_MASK;
    wire sel_word0 = wb_adr_i == OFS_WORD0;
    wire sel_state = wb_adr_i == OFS_STATE;
    wire enabled   = ctrl_reg[0];
    wire stat_rd   = bus_rd && sel_stat;
    wire mask_we   = bus_wr && sel_mask && wb_sel_i[0];
    wire ctrl_we0  = bus_wr && sel_ctrl && wb_sel_i[0];

    // unmapped offsets read as zero and still acknowledge
    wire [31:0] rd_mux =
        sel_ctrl  ? ctrl_reg :
        sel_stat  ? {{(32-EV_N){1'b0}}, ev_status} :
        sel_mask  ? {{(32-EV_N){1'b0}}, ev_mask} :
        sel_word0 ? {{(32-WORD_W){1'b0}}, word0_reg} :
        sel_state ? {28'h000_0000, 1'b0, p_dma_reg | p_exec_reg,
                     halt_pend_reg, wr_busy} :
        32'h0000_0000;

    // event qualification
    wire intr_ok    = enabled && intr_instr_i && prog_running_i; // RULE_02
    wire halt_now   = enabled && halt_io_program_command_i
                      && prog_waiting_i;                         // RULE_05
    wire halt_defer = enabled && halt_io_program_command_i
                      && prog_running_i && !prog_waiting_i;      // RULE_06
    wire halt_fire  = halt_pend_reg && wait_point_i;             // RULE_06
    wire dma_bad    = enabled && dma_check_i
                      && (dma_reg_i[DMA_BIT_HI:DMA_BIT_LO]
                          != dma_expect_i);                      // RULE_10
    wire dma_ev     = (enabled && dma_abort_i) || dma_bad;
    wire exec_ev    = enabled && exec_err_i;

    // composed information words
    wire [WORD_W-1:0] w_intr = {INTR_TOP, intr_data_i};          // RULE_04
    wire [WORD_W-1:0] w_halt = {CAUSE_HALT, {BODY_W{1'b0}}};     // RULE_07
    wire [WORD_W-1:0] w_dma  = {CAUSE_DMA,
                                dma_reg_i[WORD_W-1:CAUSE_W]};    // RULE_08
    wire [WORD_W-1:0] w_exec = {CAUSE_EXEC, exec_flags_i};       // RULE_11
    wire [WORD_W-1:0] w_xhi  = {{(WORD_W-XHI_W){1'b0}},
                                dma_xaddr_reg[XADDR_W-1:XLO_W]}; // RULE_09
    wire [WORD_W-1:0] w_xlo  = dma_xaddr_reg[XLO_W-1:0];         // RULE_09

    // launch priority: execution error, DMA abort, halt, instruction
    wire launch  = !wr_busy && !start_reg;
    wire go_exec = launch && p_exec_reg;
    wire go_dma  = launch && !p_exec_reg && p_dma_reg;
    wire go_halt = launch && !p_exec_reg && !p_dma_reg && p_halt_reg;
    wire go_intr = launch && !p_exec_reg && !p_dma_reg && !p_halt_reg
                   && p_intr_reg;

    // sticky cause bit only once the last word is in memory
    assign ev_set[EV_INTR] = wr_done && act_kind_reg == K_INTR;  // RULE_12
    assign ev_set[EV_HALT] = wr_done && act_kind_reg == K_HALT;  // RULE_12
    assign ev_set[EV_DMA]  = wr_done && act_kind_reg == K_DMA;   // RULE_12
    assign ev_set[EV_EXEC] = wr_done && act_kind_reg == K_EXEC;  // RULE_12

    // wishbone slave: one wait state, registered data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            ctrl_reg <= RST_CTRL;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_rd ? rd_mux : 32'h0000_0000;
            if (ctrl_we0)
                ctrl_reg <= {24'h00_0000, wb_dat_i[7:0]};
        end
    end

    // halt handling: immediate while waiting, held to wait point while running
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            halt_pend_reg <= 1'b0;
            halt_o        <= 1'b0;
        end
        else
        begin
            halt_o <= halt_now || halt_fire;
            if (halt_defer)
                halt_pend_reg <= 1'b1;
            else if (halt_fire || halt_now)
                halt_pend_reg <= 1'b0;
        end
    end

    // pending causes; a new event wins over the launch that clears it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            p_intr_reg      <= 1'b0;
            p_halt_reg      <= 1'b0;
            p_dma_reg       <= 1'b0;
            p_exec_reg      <= 1'b0;
            intr_word_reg   <= '0;
            intr_sel_reg    <= '0;
            dma_word_reg    <= '0;
            exec_word_reg   <= '0;
            dma_addr_ok_reg <= 1'b0;
            dma_xaddr_reg   <= '0;
        end
        else
        begin
            p_intr_reg <= intr_ok   || (p_intr_reg && !go_intr);
            p_halt_reg <= halt_fire || (p_halt_reg && !go_halt);
            p_dma_reg  <= dma_ev    || (p_dma_reg  && !go_dma);
            p_exec_reg <= exec_ev   || (p_exec_reg && !go_exec);
            if (intr_ok)
            begin
                intr_word_reg <= w_intr;
                intr_sel_reg  <= intr_word_sel_i;
            end
            if (dma_ev)
            begin
                dma_word_reg <= w_dma;
                dma_addr_ok_reg <= dma_abort_i && dma_mem_err_i
                                   && !dma_bad;                  // RULE_10
                dma_xaddr_reg <= dma_addr_i;
            end
            if (exec_ev)
                exec_word_reg <= w_exec;
        end
    end

    // job setup for the word writer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            start_reg    <= 1'b0;
            act_kind_reg <= K_NONE;
            cnt_reg      <= '0;
            a0_reg       <= '0;
            a1_reg       <= '0;
            a2_reg       <= '0;
            d0_reg       <= '0;
            d1_reg       <= '0;
            d2_reg       <= '0;
        end
        else
        begin
            start_reg <= go_exec || go_dma || go_halt || go_intr;
            a0_reg    <= WIDX_STATUS;                            // RULE_03
            a1_reg    <= WIDX_XHI;
            a2_reg    <= WIDX_XLO;
            d1_reg    <= w_xhi;
            d2_reg    <= w_xlo;
            cnt_reg   <= 2'h1;
            if (go_exec)
            begin
                act_kind_reg <= K_EXEC;
                d0_reg       <= exec_word_reg;
            end
            else if (go_dma)
            begin
                act_kind_reg <= K_DMA;
                d0_reg       <= dma_word_reg;
                cnt_reg      <= dma_addr_ok_reg ? 2'h3 : 2'h1;   // RULE_09
            end
            else if (go_halt)
            begin
                act_kind_reg <= K_HALT;
                d0_reg       <= w_halt;
            end
            else if (go_intr)
            begin
                act_kind_reg <= K_INTR;
                d0_reg       <= intr_word_reg;
                a0_reg       <= intr_sel_reg;
            end
        end
    end

    // readable copy of the last status word written to word 0
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            word0_reg <= '0;
        else if (channel_program_variable_area_we_o && channel_program_variable_area_ack_i && channel_program_variable_area_addr_o == WIDX_STATUS)
            word0_reg <= channel_program_variable_area_data_o;
    end

    cab_word_writer u_writer (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .start_i    (start_reg),
        .count_i    (cnt_reg),
        .addr0_i    (a0_reg),
        .data0_i    (d0_reg),
        .addr1_i    (a1_reg),
        .data1_i    (d1_reg),
        .addr2_i    (a2_reg),
        .data2_i    (d2_reg),
        .mem_ack_i  (channel_program_variable_area_ack_i),
        .mem_we_o   (channel_program_variable_area_we_o),
        .mem_addr_o (channel_program_variable_area_addr_o),
        .mem_data_o (channel_program_variable_area_data_o),
        .busy_o     (wr_busy),
        .done_o     (wr_done)
    );

    cab_irq_unit u_irq (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .set_i     (ev_set),
        .rd_clr_i  (stat_rd),
        .mask_we_i (mask_we),
        .mask_d_i  (wb_dat_i[EV_N-1:0]),
        .status_o  (ev_status),
        .mask_o    (ev_mask),
        .irq_o     (irq_o)
    );

    AST_INTR_WORD: assert property ( // RULE_04
        channel_program_variable_area_we_o && act_kind_reg == K_INTR
        |-> channel_program_variable_area_data_o[WORD_W-1:INTR_DW] == INTR_TOP)
        else $error("instruction word top bits not 1000");
    AST_HALT_WORD: assert property ( // RULE_07
        channel_program_variable_area_we_o && act_kind_reg == K_HALT
        |-> channel_program_variable_area_data_o == {CAUSE_HALT, {BODY_W{1'b0}}}
            && channel_program_variable_area_addr_o == WIDX_STATUS)
        else $error("deferred halt word wrong");
    AST_DMA_CAUSE: assert property ( // RULE_08
        channel_program_variable_area_we_o && act_kind_reg == K_DMA && channel_program_variable_area_addr_o == WIDX_STATUS
        |-> channel_program_variable_area_data_o[WORD_W-1:BODY_W] == CAUSE_DMA)
        else $error("dma abort cause code wrong");
    AST_EXEC_CAUSE: assert property ( // RULE_11
        channel_program_variable_area_we_o && act_kind_reg == K_EXEC
        |-> channel_program_variable_area_data_o[WORD_W-1:BODY_W] == CAUSE_EXEC
            && channel_program_variable_area_addr_o == WIDX_STATUS)
        else $error("execution error word wrong");
    AST_ABORT_WORD0: assert property ( // RULE_03
        start_reg && act_kind_reg != K_INTR |-> a0_reg == WIDX_STATUS)
        else $error("abort status not aimed at word 0");
    AST_HALT_NOW: assert property ( // RULE_05
        enabled && halt_io_program_command_i && prog_waiting_i
        |=> halt_o && !p_halt_reg)
        else $error("halt while waiting not immediate");
    AST_HALT_DEFER: assert property ( // RULE_06
        halt_defer && !wait_point_i |=> halt_pend_reg && !halt_o)
        else $error("halt during service not deferred");
    AST_NO_ADDR: assert property ( // RULE_10
        dma_bad |=> !dma_addr_ok_reg)
        else $error("mismatch abort would store address");
    AST_XHI: assert property ( // RULE_09
        channel_program_variable_area_we_o && act_kind_reg == K_DMA && channel_program_variable_area_addr_o == WIDX_XHI
        |-> channel_program_variable_area_data_o[WORD_W-1:XHI_W] == 8'h00)
        else $error("extended address not right-justified");
    AST_SET_AFTER_WRITE: assert property ( // RULE_12
        |ev_set |-> $past(channel_program_variable_area_we_o) && $past(channel_program_variable_area_ack_i))
        else $error("status set before words written");
    AST_INTR_RUNNING: assert property ( // RULE_02
        $rose(p_intr_reg) |-> $past(prog_running_i))
        else $error("instruction interrupt outside running program");
    AST_CAUSE_TOP: assert property ( // RULE_01
        channel_program_variable_area_we_o && channel_program_variable_area_addr_o == WIDX_STATUS && act_kind_reg != K_INTR
        |-> channel_program_variable_area_data_o[WORD_W-1] == 1'b1)
        else $error("cause field outside defined codes");
endmodule // cab_channel_abort_status_writer

// File: cab_channel_program_variable_area_mem.sv
// variable area memory: eight words, acks each write after delay_i cycles
module cab_channel_program_variable_area_mem
    import cab_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              we_i,
    input  wire logic [WSEL_W-1:0] addr_i,
    input  wire logic [WORD_W-1:0] data_i,
    input  wire logic [1:0]        delay_i,
    output logic                   ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [WORD_W-1:0] words [8];
    logic [1:0]        wait_reg;
    // a word lands only at the edge that raises ack; ack lasts one cycle,
    // so a held request is never taken twice
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o    <= 1'b0;
            wait_reg <= 2'h0;
            // odd fill so an unwritten word never looks like a zero word
            for (int i = 0; i < 8; i++) words[i] <= 16'h5A5A;
        end
        else if (we_i && !ack_o && wait_reg == delay_i)
        begin
            ack_o          <= 1'b1;
            wait_reg       <= 2'h0;
            words[addr_i]  <= data_i;
        end
        else
        begin
            ack_o    <= 1'b0;
            wait_reg <= (we_i && !ack_o) ? wait_reg + 2'h1 : 2'h0;
        end
    end
endmodule // cab_channel_program_variable_area_mem

// File: cab_channel_abort_status_writer_tb_top.sv
module cab_channel_abort_status_writer_tb_top
    import cab_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, mwe, mack;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, d;
    logic run = 0, wtg = 0, wpt = 0, ii = 0, hio = 0, dab = 0, merr = 0;
    logic chk = 0, xer = 0, halt, irq;
    logic [2:0] wsel = 3'h0, maddr;
    logic [11:0] idat = 12'h000;
    logic [15:0] dreg = 16'h0000, mdat, w4, w5;
    logic [23:0] daddr = 24'h000000;
    logic [1:0] dexp = 2'h0, dly = 2'h0;
    logic [12:0] xfl = 13'h0000;
    int n_mismatch = 0, n_checks = 0, n_halt = 0;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (halt === 1'b1) n_halt++;
    cab_channel_abort_status_writer dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .prog_running_i(run), .prog_waiting_i(wtg), .wait_point_i(wpt),
        .intr_instr_i(ii), .intr_word_sel_i(wsel), .intr_data_i(idat),
        .halt_io_program_command_i(hio), .dma_abort_i(dab),
        .dma_mem_err_i(merr), .dma_reg_i(dreg), .dma_addr_i(daddr),
        .dma_check_i(chk), .dma_expect_i(dexp), .exec_err_i(xer),
        .exec_flags_i(xfl), .channel_program_variable_area_ack_i(mack), .channel_program_variable_area_we_o(mwe),
        .channel_program_variable_area_addr_o(maddr), .channel_program_variable_area_data_o(mdat), .halt_o(halt),
        .irq_o(irq));
    cab_channel_program_variable_area_mem u_mem (.clk_i(clk_i), .rst_i(rst_i), .we_i(mwe),
        .addr_i(maddr), .data_i(mdat), .delay_i(dly), .ack_o(mack));
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one classic cycle; held until ack is sampled, then released
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] v, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        r = rdat;
        if (n >= 50) check("wb ack", 32'h0, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    // waits a bounded time for the interrupt level
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        check("irq raised", {31'h0, irq}, 32'h1);
    endtask
    task automatic status_is(input logic [3:0] exp);
        wb(1'b0, OFS_STATUS, 32'h0, d);
        check("status", d, {28'h0, exp});
        check("irq after clear", {31'h0, irq}, 32'h0);
    endtask
    task automatic t_reset();
        wb(1'b0, OFS_CTRL, 32'h0, d); check("ctrl", d, RST_CTRL);
        wb(1'b0, OFS_MASK, 32'h0, d); check("mask", d, {28'h0, RST_MASK});
        wb(1'b0, 8'h1C, 32'h0, d); check("unmapped", d, 32'h0);
        wb(1'b1, OFS_MASK, 32'hF, d);
    endtask
    task automatic t_intr();
        // software keeps word 0 free for aborts
        run <= 1'b1; ii <= 1'b1; wsel <= 3'h2; idat <= 12'hABC;
        @(posedge clk_i);
        ii <= 1'b0;
        wait_irq();
        check("intr word", u_mem.words[2], {INTR_TOP, 12'hABC});
        check("intr cause", u_mem.words[2][15:13], CAUSE_INTR);
        status_is(4'h1);
        run <= 1'b0; ii <= 1'b1; wsel <= 3'h1;
        @(posedge clk_i);
        ii <= 1'b0;
        repeat (12) @(posedge clk_i);
        check("idle intr", u_mem.words[1], 16'h5A5A);
        status_is(4'h0);
    endtask
    task automatic t_halt();
        run <= 1'b1; wtg <= 1'b1; hio <= 1'b1;
        @(posedge clk_i);
        hio <= 1'b0; wtg <= 1'b0;
        repeat (8) @(posedge clk_i);
        check("quiet halt", n_halt, 1);
        check("quiet word", u_mem.words[0], 16'h5A5A);
        status_is(4'h0);
        hio <= 1'b1;
        @(posedge clk_i);
        hio <= 1'b0;
        repeat (8) @(posedge clk_i);
        check("halt deferred", n_halt, 1);
        wb(1'b0, OFS_STATE, 32'h0, d);
        check("state pending", d, 32'h2);
        wpt <= 1'b1;
        @(posedge clk_i);
        wpt <= 1'b0;
        wait_irq();
        check("halt pulse", n_halt, 2);
        check("halt word", u_mem.words[0], {CAUSE_HALT, 13'h0});
        wb(1'b0, OFS_WORD0, 32'h0, d); check("word0 reg", d, 32'hA000);
        status_is(4'h2);
    endtask
    task automatic t_dma();
        dly <= 2'h2; dab <= 1'b1; merr <= 1'b1;
        dreg <= 16'hBEEF; daddr <= 24'hC3_1234;
        @(posedge clk_i);
        dab <= 1'b0; merr <= 1'b0;
        wait_irq();
        check("dma word", u_mem.words[0], {CAUSE_DMA, 13'h17DD});
        check("addr hi", u_mem.words[4], 16'h00C3);
        check("addr lo", u_mem.words[5], 16'h1234);
        status_is(4'h4);
        w4 = u_mem.words[4]; w5 = u_mem.words[5];
        dly <= 2'h0; chk <= 1'b1; dexp <= 2'h0; dreg <= 16'h0600;
        daddr <= 24'h00_0000;
        @(posedge clk_i);
        chk <= 1'b0;
        wait_irq();
        check("mism word", u_mem.words[0], {CAUSE_DMA, 13'h00C0});
        check("mism hi", u_mem.words[4], w4);
        check("mism lo", u_mem.words[5], w5);
        status_is(4'h4);
    endtask
    task automatic t_exec();
        dly <= 2'h1; xer <= 1'b1; xfl <= 13'h1A05;
        @(posedge clk_i);
        xer <= 1'b0;
        wait_irq();
        check("exec word", u_mem.words[0], {CAUSE_EXEC, 13'h1A05});
        status_is(4'h8);
        // both pending: the error word goes first, the abort word last
        dab <= 1'b1;
        xer <= 1'b1;
        @(posedge clk_i);
        dab <= 1'b0;
        xer <= 1'b0;
        repeat (20) @(posedge clk_i);
        check("both word", u_mem.words[0], {CAUSE_DMA, 13'h00C0});
        status_is(4'hC);
    endtask
    // a masked cause sets its bit quietly; a disabled block drops events
    task automatic t_mask();
        wb(1'b1, OFS_MASK, 32'h7, d);
        wb(1'b0, OFS_MASK, 32'h0, d);
        check("mask", d, 32'h7);
        xer <= 1'b1;
        @(posedge clk_i);
        xer <= 1'b0;
        repeat (12) @(posedge clk_i);
        check("masked irq", {31'h0, irq}, 32'h0);
        status_is(4'h8);
        wb(1'b1, OFS_CTRL, 32'h0, d);
        xer <= 1'b1;
        @(posedge clk_i);
        xer <= 1'b0;
        repeat (12) @(posedge clk_i);
        status_is(4'h0);
        wb(1'b1, OFS_CTRL, 32'h1, d);
        wb(1'b1, OFS_MASK, 32'hF, d);
    endtask
    initial
    begin
        #(100 * 3000);
        n_mismatch++;
        wrap_up();
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_intr();
        t_halt();
        t_dma();
        t_exec();
        t_mask();
        wrap_up();
    end
endmodule // cab_channel_abort_status_writer_tb_top
